// File: common/bli_pkg.sv
package bli_pkg;
   // register indices; byte address is four times the index
   localparam int                ADDR_W   = 12;
   localparam logic [7:0]        IDX_CTRL = 8'hD8;
   localparam logic [7:0]        IDX_DATA = 8'hD9;
   localparam logic [7:0]        IDX_CFG  = 8'hDA;
   localparam logic [ADDR_W-1:0] ADR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_DATA = {2'h0, IDX_DATA, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_CFG  = {2'h0, IDX_CFG, 2'h0};
   // control write bits
   localparam int CB_CXA  = 7;
   localparam int CB_IDLE = 6;
   localparam int CB_CDR  = 5;
   localparam int CB_CLEAR_ARBITRATION_LOST = 4;
   localparam int CB_CLEAR_START_SEEN = 3;
   localparam int CB_CLEAR_STOP_SEEN = 2;
   localparam int CB_SEND_REPEATED_START = 1;
   localparam int CB_SEND_STOP = 0;
   // configuration bits
   localparam int CF_SLVEN = 7;
   localparam int CF_MRQ   = 6;
   localparam int CF_TIE   = 5;
   localparam int CF_TRUN  = 4;
   localparam logic [7:0] CFG_RST = 8'h00;
   // bus timer
   localparam logic [2:0] MC_LAST  = 3'h5;   // six clocks per machine cycle
   localparam logic [9:0] TMR_MIN  = 10'h008;
   localparam logic [9:0] TMR_LAST = 10'h3FF;
   localparam logic [2:0] MIN_CT10 = 3'h7;
   localparam logic [2:0] MIN_CT01 = 3'h6;
   localparam logic [2:0] MIN_CT00 = 3'h5;
   localparam logic [2:0] MIN_CT11 = 3'h4;
   // master clock generator states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_LOW   = 3'b010,
      ST_HIGH  = 3'b011,
      ST_COND  = 3'b100
   } bli_st_t;
endpackage

// File: common/bli_tmr_if.sv
`timescale 1ns/1ps
// control of the bus timer
interface bli_tmr_if;
   logic       restart;   // preload on scl change
   logic       run_full;  // high bits may count
   logic [1:0] ct;        // timing select
   logic       min_done;  // minimum time elapsed
   logic       timeout;   // carry out pulse
   modport ctl (output restart, run_full, ct, input min_done, timeout);
   modport tmr (input restart, run_full, ct, output min_done, timeout);
endinterface

// File: core/bli_timer.sv
`timescale 1ns/1ps
module bli_timer
   import bli_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   bli_tmr_if.tmr   t
);
   logic [2:0] mc_q;     // machine cycle prescaler
   logic [9:0] cnt_q;    // timer count
   logic [2:0] min_cnt;  // selected minimum count
   logic       tick;     // one machine cycle done
   logic       to_q;     // carry out pulse

   // timing select map
   always_comb begin
      case (t.ct)
         2'b10:   min_cnt = MIN_CT10;
         2'b01:   min_cnt = MIN_CT01;
         2'b00:   min_cnt = MIN_CT00;
         default: min_cnt = MIN_CT11;
      endcase
   end

   assign tick       = (mc_q == MC_LAST);
   assign t.min_done = (cnt_q >= TMR_MIN);
   assign t.timeout  = to_q;

   // prescaler, restarted with the timer so min time is exact
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mc_q <= 3'h0;
      end else if (ce) begin
         mc_q <= (t.restart || tick) ? 3'h0 : mc_q + 3'h1;
      end
   end

   // counter; saturates at the min mark outside frames
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= TMR_MIN;
         to_q  <= 1'b0;
      end else if (ce) begin
         to_q <= 1'b0;
         if (t.restart) begin
            cnt_q <= TMR_MIN - {7'h0, min_cnt};
         end else if (tick) begin
            if (t.run_full && cnt_q == TMR_LAST) begin
               cnt_q <= TMR_MIN;
               to_q  <= 1'b1;
            end else if (t.run_full || cnt_q < TMR_MIN) begin
               cnt_q <= cnt_q + 10'h001;
            end
         end
      end
   end

   preload_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && t.restart |=> cnt_q == TMR_MIN - {7'h0, $past(min_cnt)})
      else $error("bus timer preload wrong");
endmodule // bli_timer

// File: core/bli_top.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
module bli_top
   import bli_pkg::*;
(
   input  wire logic              MCLK,
   input  wire logic              RESETN,
   input  wire logic              CLK_EN,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              SCL_IN,
   output logic                   SCL_OUT,
   output logic                   SCL_OE,
   input  wire logic              SDA_IN,
   output logic                   SDA_OUT,
   output logic                   SDA_OE,
   output logic                   TIMER_IRQ
);
   bli_tmr_if tif ();

   // pin synchronisers and edge history
   logic    scl_m_q, scl_s_q, scl_p_q;
   logic    sda_m_q, sda_s_q, sda_p_q;
   // flags and state
   logic    rx_bit_q;       // receive_bit
   logic    xmit_q;         // transmit_bit
   logic    data_ready_q;         // data_ready
   logic    arl_q;          // arbitration_lost
   logic    str_q;          // start_seen
   logic    stp_q;          // stop_seen
   logic    xact_q;         // transmit active
   logic    master_q;       // currently master
   logic    busy_q;         // frame in progress
   logic    idle_q;         // slave ignores bus
   logic    quit_q;         // stop requested with request cleared
   logic    rs_q;           // repeated start pending
   logic    sp_q;           // stop pending
   logic    sda_low_q;      // sda pulled low
   logic    scl_low_q;      // scl pulled low
   logic    irq_q;          // timer interrupt pulse
   logic [7:0] cfg_q;       // bus_configuration
   logic [31:0] prdata_q;   // read data
   bli_st_t st_q, st_d;     // master clock state
   // decoded strobes and events
   logic    acc, wr, rd, mapped, wr_ctl, wr_dat, rd_dat;
   logic    scl_rise, scl_fall, start_det, stop_det;
   logic    active, listen, own_cond, attention, tmo;
   logic    arl_set;
   logic [7:0] status;

   // apb slave: zero wait states while enabled
   assign acc     = PSEL && PENABLE && CLK_EN;
   assign mapped  = (PADDR == ADR_CTRL) || (PADDR == ADR_DATA) || (PADDR == ADR_CFG);
   assign wr      = acc && PWRITE;
   assign rd      = acc && !PWRITE;
   assign wr_ctl  = wr && (PADDR == ADR_CTRL);
   assign wr_dat  = wr && (PADDR == ADR_DATA);
   assign rd_dat  = rd && (PADDR == ADR_DATA);
   assign PREADY  = CLK_EN;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign PRDATA  = prdata_q;

   // bus events seen after the synchronisers
   assign scl_rise  = scl_s_q && !scl_p_q;
   assign scl_fall  = !scl_s_q && scl_p_q;
   assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   assign stop_det  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
   assign active    = cfg_q[CF_SLVEN] || cfg_q[CF_MRQ] || master_q;
   assign listen    = active && (!idle_q || master_q);
   // own conditions are not reported back to software
   assign own_cond  = (st_q == ST_START) || (st_q == ST_COND);
   assign attention = data_ready_q || arl_q || str_q || stp_q;
   assign tmo       = tif.timeout;
   assign status    = {rx_bit_q, attention, data_ready_q, arl_q, str_q, stp_q,
                       master_q, xact_q};

   // bus timer hookup
   assign tif.restart  = scl_rise || scl_fall || start_det || stop_det
                         || (st_d != st_q);
   assign tif.run_full = cfg_q[CF_TRUN] && busy_q;
   assign tif.ct       = cfg_q[1:0];

   bli_timer u_tmr (
      .clk   (MCLK),
      .rst_n (RESETN),
      .ce    (CLK_EN),
      .t     (tif.tmr)
   );

   // two flops per pin, third for edges
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      end else if (CLK_EN) begin
         {scl_m_q, scl_s_q, scl_p_q} <= {SCL_IN, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {SDA_IN, sda_m_q, sda_s_q};
      end
   end

   // read data captured in the setup phase
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         prdata_q <= 32'h0;
      end else if (CLK_EN && PSEL && !PENABLE) begin
         case (PADDR)
            ADR_CTRL: prdata_q <= {24'h0, status};
            ADR_DATA: prdata_q <= {24'h0, rx_bit_q, 7'h0};
            ADR_CFG:  prdata_q <= {24'h0, cfg_q};
            default:  prdata_q <= 32'h0;
         endcase
      end
   end

   // configuration register
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg_q <= CFG_RST;
      end else if (CLK_EN && wr && PADDR == ADR_CFG) begin
         cfg_q <= PWDATA[7:0];
      end
   end

   // arbitration loss cases, only while transmitting
   always_comb begin
      arl_set = 1'b0;
      if (xact_q) begin
         if (scl_rise && xmit_q && !sda_s_q)
            arl_set = 1'b1;
         if (start_det && xmit_q && !own_cond)
            arl_set = 1'b1;
         if (st_q == ST_HIGH && rs_q && scl_fall)
            arl_set = 1'b1;
         if (st_q == ST_COND && sp_q && tif.min_done && !sda_s_q)
            arl_set = 1'b1;
      end
   end

   // receive bit, sampled at every scl rise while active
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_bit_q <= 1'b0;
      end else if (CLK_EN && active && scl_rise) begin
         rx_bit_q <= sda_s_q;
      end
   end

   // status flags: a set in the same cycle beats a software clear; a timeout clears all
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         data_ready_q <= 1'b0;
         arl_q  <= 1'b0;
         str_q  <= 1'b0;
         stp_q  <= 1'b0;
      end else if (CLK_EN) begin
         if (tmo) begin
            {data_ready_q, arl_q, str_q, stp_q} <= 4'h0;
         end else begin
            if (scl_rise && listen)
               data_ready_q <= 1'b1;
            else if (rd_dat || wr_dat || (wr_ctl && PWDATA[CB_CDR]))
               data_ready_q <= 1'b0;
            if (arl_set)
               arl_q <= 1'b1;
            else if (wr_ctl && PWDATA[CB_CLEAR_ARBITRATION_LOST])
               arl_q <= 1'b0;
            if (start_det && listen && !own_cond)
               str_q <= 1'b1;
            else if (wr_ctl && PWDATA[CB_CLEAR_START_SEEN])
               str_q <= 1'b0;
            if (stop_det && listen && !own_cond)
               stp_q <= 1'b1;
            else if (wr_ctl && PWDATA[CB_CLEAR_STOP_SEEN])
               stp_q <= 1'b0;
         end
      end
   end

   // transmit active, transmit bit and pending conditions
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         xact_q <= 1'b0;
         xmit_q <= 1'b1;
         rs_q   <= 1'b0;
         sp_q   <= 1'b0;
      end else if (CLK_EN) begin
         if (tmo || arl_set) begin
            xact_q <= 1'b0;
            rs_q   <= 1'b0;
            sp_q   <= 1'b0;
         end else if (st_d == ST_START && st_q != ST_START) begin
            xact_q <= 1'b1;
            xmit_q <= 1'b0;
         end else if (st_q == ST_START && st_d == ST_LOW) begin
            xact_q <= 1'b0;
            xmit_q <= 1'b1;
         end else if (wr_ctl && (PWDATA[CB_SEND_REPEATED_START] || PWDATA[CB_SEND_STOP])) begin
            xact_q <= 1'b1;
            xmit_q <= PWDATA[CB_SEND_REPEATED_START];
            rs_q   <= PWDATA[CB_SEND_REPEATED_START];
            sp_q   <= !PWDATA[CB_SEND_REPEATED_START];
         end else if (wr_dat) begin
            xact_q <= 1'b1;
            xmit_q <= PWDATA[7];
         end else if (rd_dat || (wr_ctl && PWDATA[CB_CXA])) begin
            xact_q <= 1'b0;
         end else if (st_q == ST_COND && st_d != ST_COND) begin
            rs_q <= 1'b0;
            sp_q <= 1'b0;
            if (sp_q)
               xact_q <= 1'b0;
         end
      end
   end

   // bus busy, idle slave and quit request
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         busy_q <= 1'b0;
         idle_q <= 1'b1;
         quit_q <= 1'b0;
      end else if (CLK_EN) begin
         if (tmo || stop_det)
            busy_q <= 1'b0;
         else if (start_det)
            busy_q <= 1'b1;
         if (start_det)
            idle_q <= 1'b0;
         else if (wr_ctl && PWDATA[CB_IDLE])
            idle_q <= 1'b1;
         if (!master_q)
            quit_q <= 1'b0;
         else if (wr_ctl && PWDATA[CB_SEND_STOP] && !cfg_q[CF_MRQ])
            quit_q <= 1'b1;
      end
   end

   // mastership; a stop frees the bus even for an idle slave
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         master_q <= 1'b0;
      end else if (CLK_EN) begin
         if (tmo || arl_set)
            master_q <= 1'b0;
         else if (quit_q && st_q == ST_COND && st_d == ST_IDLE)
            master_q <= 1'b0;
         else if (cfg_q[CF_MRQ] && !busy_q && !stop_det)
            master_q <= 1'b1;
      end
   end

   // master clock sequencer; timer restarts on every move
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:
            if (master_q && !busy_q && scl_s_q && sda_s_q && tif.min_done)
               st_d = ST_START;
         ST_START:
            if (tif.min_done)
               st_d = ST_LOW;
         ST_LOW:
            if (tif.min_done && !attention && sda_low_q == (xact_q && !xmit_q))
               st_d = ST_HIGH;
         ST_HIGH:
            if (scl_s_q && !scl_rise && tif.min_done)
               st_d = (rs_q || sp_q) ? ST_COND : ST_LOW;
         ST_COND:
            if (tif.min_done)
               st_d = sp_q ? ST_IDLE : ST_LOW;
         default:
            st_d = ST_IDLE;
      endcase
      if (tmo || arl_set || !master_q)
         st_d = ST_IDLE;
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         st_q <= ST_IDLE;
      else if (CLK_EN)
         st_q <= st_d;
   end

   // pin drivers, both from flops
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         sda_low_q <= 1'b0;
         scl_low_q <= 1'b0;
      end else if (CLK_EN) begin
         if (!xact_q || tmo || arl_set)
            sda_low_q <= 1'b0;
         else if (st_q == ST_START)
            sda_low_q <= 1'b1;
         else if (st_q == ST_COND)
            sda_low_q <= rs_q;
         else if (!scl_s_q)
            sda_low_q <= !xmit_q;
         // slave stretches once scl is seen low
         scl_low_q <= !tmo && ((st_d == ST_LOW)
                      || (!master_q && listen && !scl_s_q && attention));
      end
   end

   // timer interrupt pulse when enabled
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         irq_q <= 1'b0;
      else if (CLK_EN)
         irq_q <= tmo && cfg_q[CF_TIE];
   end

   assign SDA_OUT   = 1'b0;
   assign SDA_OE    = sda_low_q;
   assign SCL_OUT   = 1'b0;
   assign SCL_OE    = scl_low_q;
   assign TIMER_IRQ = irq_q;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   rx_capture_a: assert property (CLK_EN && active && scl_rise
      |=> rx_bit_q == $past(sda_s_q)) else $error("receive bit not captured");
   rd_clear_a: assert property (rd_dat && !tmo && !(scl_rise && listen)
      |=> !data_ready_q && !xact_q) else $error("data read did not clear");
   wr_load_a: assert property (wr_dat && !tmo && !arl_set
      |=> xact_q && xmit_q == $past(PWDATA[7])) else $error("data write not loaded");
   sda_xact_a: assert property (SDA_OE |-> $past(xact_q))
      else $error("sda driven while not transmitting");
   arl_one_a: assert property (CLK_EN && xact_q && xmit_q && scl_rise && !sda_s_q
      && !tmo |=> arl_q && !xact_q) else $error("lost arbitration missed");
   stretch_a: assert property (CLK_EN && !tmo && !master_q && listen && !scl_s_q
      && attention |=> SCL_OE) else $error("scl not stretched");
   data_ready_set_a: assert property (CLK_EN && !tmo && scl_rise && listen
      |=> data_ready_q) else $error("data ready not set");
   idle_start_a: assert property (CLK_EN && !tmo && start_det && idle_q && !master_q
      && !str_q |=> !str_q) else $error("idle slave flagged start");
   grant_a: assert property (CLK_EN && cfg_q[CF_MRQ] && !busy_q && !stop_det && !tmo
      && !arl_set |=> master_q) else $error("mastership not granted");
   timeout_a: assert property (CLK_EN && tmo |=> !SCL_OE && !master_q
      && !attention) else $error("timeout did not reset");

   start_c: cover property (st_q == ST_START ##1 st_q == ST_LOW);
   arl_c: cover property ($rose(arl_q));
   stop_c: cover property (st_q == ST_COND && sp_q ##1 st_q == ST_IDLE);
   tmo_c: cover property (tmo);
endmodule // bli_top

// File: sim/bli_bus_model.sv
`timescale 1ns/1ps
// another bus master on the two open-drain wires, with pull-ups
module bli_bus_model (
   input  wire logic scl_oe_dev,   // device pulls scl low
   input  wire logic sda_oe_dev,   // device pulls sda low
   output logic      scl,          // resolved scl level
   output logic      sda           // resolved sda level
);
   logic m_scl;   // model pulls scl low
   logic m_sda;   // model pulls sda low

   // wired-and; a released line floats to the pull-up level
   assign scl = ~(scl_oe_dev | m_scl);
   assign sda = ~(sda_oe_dev | m_sda);

   // bus idle: both lines released, no clock between frames
   initial begin
      m_scl = 1'b0;
      m_sda = 1'b0;
   end

   // start: sda falls while scl high, then scl low
   task automatic gen_start();
      m_sda = 1'b1;
      #100;
      m_scl = 1'b1;
      #100;
   endtask

   // one bit; waits while the device stretches scl low
   task automatic send_bit(input logic b);
      m_sda = ~b;
      #100;
      m_scl = 1'b0;
      wait (scl === 1'b1);
      #100;
      m_scl = 1'b1;
      #100;
   endtask

   // stop: sda low under a clock, then sda released while scl high
   task automatic gen_stop();
      m_sda = 1'b1;
      #100;
      m_scl = 1'b0;
      wait (scl === 1'b1);
      #100;
      m_sda = 1'b0;
      #100;
   endtask
endmodule // bli_bus_model

// File: sim/test_bli_top.sv
`timescale 1ns/1ps
// bench: apb register tasks plus a second bus master on the wires
module test_bli_top;
   import bli_pkg::*;
   logic              MCLK;       // 40 MHz clock
   logic              RESETN;     // async reset
   logic              CLK_EN;     // clock enable
   logic              PSEL;       // apb select
   logic              PENABLE;    // apb enable
   logic              PWRITE;     // apb direction
   logic [ADDR_W-1:0] PADDR;      // apb address
   logic [31:0]       PWDATA;     // apb write data
   logic [31:0]       PRDATA;     // apb read data
   logic              PREADY;     // apb ready
   logic              PSLVERR;    // apb error
   logic              SCL_OE;     // device pulls scl
   logic              SDA_OE;     // device pulls sda
   logic              TIMER_IRQ;  // timer carry pulse
   logic              scl;        // resolved scl
   logic              sda;        // resolved sda
   logic [31:0]       rd;         // last read data
   logic              err;        // last error flag
   int                n_mismatch; // mismatches seen
   int                checks;     // comparisons made
   int                i;          // wait counter
   int                t0;         // cycle stamp

   bli_top dut_u (.MCLK(MCLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_IN(scl),
      .SCL_OUT(), .SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(SDA_OE),
      .TIMER_IRQ(TIMER_IRQ));

   bli_bus_model bus_u (.scl_oe_dev(SCL_OE), .sda_oe_dev(SDA_OE), .scl(scl), .sda(sda));

   // 25 ns clock
   initial begin
      MCLK = 1'b0;
      forever #12.5 MCLK = ~MCLK;
   end

   // verdict and end of run
   task automatic final_report();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // compare seen against expected
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge MCLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= {24'h000000, d};
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      rd  = PRDATA;
      err = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   // read a register and compare
   task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 8'h00);
      chk(nm, rd, e);
   endtask

   // let the synchronisers settle, then compare a pin enable
   task automatic pin(input string nm, input logic got_sel, input logic e);
      repeat (12) @(posedge MCLK);
      chk(nm, {31'h0, (got_sel ? SCL_OE : SDA_OE)}, {31'h0, e});
   endtask

   // watchdog: whole run, bus timer span included, is under ten thousand cycles
   initial begin
      repeat (20000) @(posedge MCLK);
      n_mismatch++;
      final_report();
   end

   // main sequence; bus timer left off until the last step, which trips the hang reset
   initial begin
      n_mismatch = 0;
      checks = 0;
      RESETN = 1'b0;
      CLK_EN = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = '0;
      PWDATA = 32'h00000000;
      repeat (3) @(posedge MCLK);
      RESETN <= 1'b1;
      // frozen block holds its bus answer back
      CLK_EN <= 1'b0;
      @(posedge MCLK);
      chk("pready_off", {31'h0, PREADY}, 32'h00000000);
      CLK_EN <= 1'b1;
      rchk("status_rst", ADR_CTRL, 32'h00000000);
      rchk("cfg_rst", ADR_CFG, 32'h00000000);
      rchk("unmapped", 12'h000, 32'h00000000);
      chk("slverr", {31'h0, err}, 32'h00000001);
      apb(1'b1, ADR_CFG, 8'h80);
      rchk("cfg_rw", ADR_CFG, 32'h00000080);
      // idle slave woken by a start: no start flag
      bus_u.gen_start();
      rchk("wake", ADR_CTRL, 32'h00000000);
      bus_u.send_bit(1'b1);
      rchk("rx_one", ADR_CTRL, 32'h000000E0);
      pin("stretch", 1'b1, 1'b1);
      rchk("data_rd", ADR_DATA, 32'h00000080);
      rchk("rd_clr", ADR_CTRL, 32'h00000080);
      // transmit a zero; the pull appears while scl is low
      apb(1'b1, ADR_DATA, 8'h00);
      rchk("xa_set", ADR_CTRL, 32'h00000081);
      pin("sda_drv", 1'b0, 1'b1);
      bus_u.send_bit(1'b1);
      rchk("tx_zero", ADR_CTRL, 32'h00000061);
      apb(1'b1, ADR_CTRL, 8'hA0);
      rchk("cxa_cdr", ADR_CTRL, 32'h00000000);
      pin("sda_rel", 1'b0, 1'b0);
      // send a one against a zero: arbitration lost
      apb(1'b1, ADR_DATA, 8'h80);
      bus_u.send_bit(1'b0);
      rchk("arl", ADR_CTRL, 32'h00000070);
      apb(1'b1, ADR_CTRL, 8'h20);
      pin("hold_arl", 1'b1, 1'b1);
      // software answers well inside the bus timer span
      apb(1'b1, ADR_CTRL, 8'h10);
      rchk("clear_arbitration_lost", ADR_CTRL, 32'h00000000);
      for (i = 0; i < 60 && SCL_OE !== 1'b0; i++) @(posedge MCLK);
      chk("scl_rel", {31'h0, SCL_OE}, 32'h00000000);
      // stop at a non-idle slave
      bus_u.gen_stop();
      rchk("stop", ADR_CTRL, 32'h00000064);
      apb(1'b1, ADR_CTRL, 8'h24);
      rchk("clear_stop_seen", ADR_CTRL, 32'h00000000);
      // bus free after the stop: master request is granted, select 10 gives 7 cycles
      apb(1'b1, ADR_CFG, 8'hC2);
      apb(1'b0, ADR_CTRL, 8'h00);
      chk("master", rd & 32'h00000002, 32'h00000002);
      for (i = 0; i < 200 && SDA_OE !== 1'b1; i++) @(posedge MCLK);
      chk("own_start", {31'h0, SDA_OE}, 32'h00000001);
      for (i = 0; i < 200 && SCL_OE !== 1'b1; i++) @(posedge MCLK);
      chk("min_time", {31'h0, (i >= 42 && i < 200)}, 32'h00000001);
      // each scl phase lasts at least seven machine cycles of six clocks
      for (t0 = 0; t0 < 200 && SCL_OE === 1'b1; t0++) @(posedge MCLK);
      chk("min_low", {31'h0, (t0 >= 42 && t0 < 200)}, 32'h00000001);
      for (i = 0; i < 200 && SCL_OE !== 1'b1; i++) @(posedge MCLK);
      chk("min_high", {31'h0, (i >= 42 && i < 200)}, 32'h00000001);
      rchk("m_bit", ADR_CTRL, 32'h000000E2);
      // last message done: request cleared before the stop
      apb(1'b1, ADR_CFG, 8'h82);
      apb(1'b1, ADR_CTRL, 8'h21);
      repeat (300) @(posedge MCLK);
      rchk("own_stop", ADR_CTRL, 32'h00000060);
      pin("stop_sda", 1'b0, 1'b0);
      // start at a non-idle slave, then a stuck clock trips the bus timer
      apb(1'b1, ADR_CFG, 8'hB3);
      bus_u.gen_start();
      rchk("start_seen", ADR_CTRL, 32'h00000068);
      for (i = 0; i < 8000 && TIMER_IRQ !== 1'b1; i++) @(posedge MCLK);
      chk("timer_irq", {31'h0, TIMER_IRQ}, 32'h00000001);
      rchk("tmo_rst", ADR_CTRL, 32'h00000000);
      pin("tmo_scl", 1'b1, 1'b0);
      final_report();
   end
endmodule // test_bli_top
